//--- dv/dmi_init_seq_asserts.sv
// Checker for the DDR2 start-up sequencer's command bus.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "dmi_consts.svh"
module dmi_init_seq_asserts
    import dmi_pkg::*;
#(
    parameter int unsigned STABLE_CYC = 4000,
    parameter int unsigned REFRESH_CNT = 2
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Watched outputs
    input wire dmi_pkg::dmi_cmd_t cmd_out,
    input wire logic done_out,
    input wire logic read_ok_out
);
    logic [3:0] code;
    logic dll_rst;
    logic [31:0] low_ff;
    logic [15:0] dll_ff;
    logic [3:0] ref_ff;
    assign code = {cmd_out.cs_n, cmd_out.ras_n, cmd_out.cas_n, cmd_out.we_n};
    assign dll_rst = code == `DMI_CMD_MODE_SET && cmd_out.bank == 2'h0 && cmd_out.addr[8];
    // Only the DLL count saturates; the low and refresh counts wrap on long runs
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            low_ff <= 32'h0000_0000;
            dll_ff <= 16'h0000;
            ref_ff <= 4'h0;
        end else begin
            low_ff <= cmd_out.cke ? 32'h0000_0000 : low_ff + 32'h0000_0001;
            dll_ff <= dll_rst ? 16'h0000 : dll_ff + {15'h0000, dll_ff != 16'hFFFF};
            ref_ff <= dll_rst ? 4'h0 : ref_ff + {3'h0, code == `DMI_CMD_REFRESH};
        end
    end
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    sequence nop_s;
        code == `DMI_CMD_NOP && cmd_out.cke;
    endsequence
    sequence mode_s(logic [1:0] b);
        code == `DMI_CMD_MODE_SET && cmd_out.bank == b;
    endsequence
    sequence dll_en_s;
        mode_s(2'h1) ##0 (cmd_out.addr[9:7] == 3'h0 && !cmd_out.addr[0] && !cmd_out.addr[13]);
    endsequence
    sequence main_run_s;
        mode_s(2'h0) ##0 !cmd_out.addr[8];
    endsequence
    sequence cal_def_s;
        mode_s(2'h1) ##0 cmd_out.addr[9:7] == 3'h7;
    endsequence
    sequence cal_exit_s;
        mode_s(2'h1) ##0 cmd_out.addr[9:7] == 3'h0;
    endsequence
    a_reset_quiet: assert property ($fell(sys_rst_in) |-> !cmd_out.cke && cmd_out.cs_n)
        else $error("bus busy after reset");
    a_bus_legal: assert property (!cmd_out.termination_control
        && (cmd_out.cs_n || code inside {4'h0, 4'h1, 4'h2, 4'h7}))
        else $error("illegal command");
    a_stable_wait: assert property ($rose(cmd_out.cke) |->
        low_ff >= STABLE_CYC ##0 nop_s[*8]) else $error("clock enable too early");
    a_mode_gap: assert property (code == `DMI_CMD_MODE_SET |=> nop_s[*2])
        else $error("mode write gap short");
    a_dll_order: assert property (mode_s(2'h3) |-> ##3 dll_en_s
        ##3 (dll_rst && !cmd_out.addr[13])) else $error("dll steps");
    a_refresh_cnt: assert property (main_run_s |-> ref_ff >= REFRESH_CNT)
        else $error("too few refreshes");
    a_cal_wait: assert property (cal_def_s |-> dll_ff >= 16'h00C7)
        else $error("calibration too early");
    a_cal_exit: assert property (cal_def_s |-> ##3 cal_exit_s)
        else $error("no calibration exit");
    a_read_gap: assert property (read_ok_out |-> done_out && dll_ff >= 16'h00C7)
        else $error("read allowed too early");
endmodule : dmi_init_seq_asserts
bind dmi_init_seq dmi_init_seq_asserts #(.STABLE_CYC(STABLE_CYC), .REFRESH_CNT(REFRESH_CNT)) chk_u (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cmd_out(cmd_out), .done_out(done_out),
    .read_ok_out(read_ok_out));

//--- dv/dmi_mem_model.sv
// Behavioural DDR2 memory decoding the sequencer's commands.
// Assumes commands are sampled on rising edges of the shared clock.
`timescale 1ns/1ps
`include "dmi_consts.svh"
module dmi_mem_model
    import dmi_pkg::*;
(
    // Clock and bench clear
    input wire logic clk_in,
    input wire logic clr_in,
    // Command bus
    input wire dmi_pkg::dmi_cmd_t cmd_in,
    // Observed device state
    output logic [13:0] mr_out [4],
    output logic [13:0] ref_cnt_out,
    output logic [13:0] dll_cnt_out,
    output logic [13:0] e1_cnt_out,
    output logic [13:0] err_cnt_out
);
    logic [3:0] code;
    logic idle_ff;
    assign code = {cmd_in.cs_n, cmd_in.ras_n, cmd_in.cas_n, cmd_in.we_n};
    // Registers stay undefined; the clear touches bookkeeping only
    always @(posedge clk_in) begin
        if (clr_in) begin
            idle_ff <= 1'b0;
            ref_cnt_out <= 14'h0000;
            dll_cnt_out <= 14'h0000;
            e1_cnt_out <= 14'h0000;
            err_cnt_out <= 14'h0000;
        end else if (cmd_in.cke) begin
            if (code == `DMI_CMD_PRECHARGE && cmd_in.addr[10]) begin
                idle_ff <= 1'b1;
            end
            if (code == `DMI_CMD_REFRESH) begin
                ref_cnt_out <= ref_cnt_out + 14'h0001;
            end
            if (code == `DMI_CMD_MODE_SET) begin
                mr_out[cmd_in.bank] <= cmd_in.addr;
                err_cnt_out <= err_cnt_out + {13'h0000, !idle_ff};
                if (cmd_in.bank == 2'h0 && cmd_in.addr[8]) begin
                    dll_cnt_out <= dll_cnt_out + 14'h0001;
                    ref_cnt_out <= 14'h0000;
                    e1_cnt_out <= 14'h0000;
                end else if (cmd_in.bank == 2'h1) begin
                    e1_cnt_out <= e1_cnt_out + 14'h0001;
                end
            end
        end
    end
endmodule : dmi_mem_model

//--- dv/tb_dmi_init_seq.sv
// Self-checking bench: sequencer drives a memory model.
// Assumes a short power-up count so each start-up stays brief.
`timescale 1ns/1ps
`include "dmi_consts.svh"
module tb_dmi_init_seq;
    import dmi_pkg::*;
    typedef struct packed {
        dmi_regs_t regs;
        logic [13:0] exp_main;
        logic [13:0] exp_ext1;
    } dmi_row_t;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic start_in = 1'b0;
    dmi_regs_t regs_in = '0;
    dmi_cmd_t cmd_out;
    logic mem_clk_en_out, busy_out, done_out, read_ok_out;
    logic [13:0] mr [4];
    logic [13:0] n_ref, n_dll, n_e1, n_err;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    // Final main write clears A8 and A7; final ext1 clears A9..A7
    dmi_row_t rows [3] = '{
        '{'{14'h0B63, 14'h0784, 14'h0080, 14'h0000}, 14'h0A63, 14'h0404},
        '{'{14'h0A42, 14'h0046, 14'h0000, 14'h0000}, 14'h0A42, 14'h0046},
        '{'{14'h04F3, 14'h0001, 14'h0080, 14'h0000}, 14'h0473, 14'h0001}};
    always #25 clk_in = ~clk_in;
    dmi_init_seq #(.STABLE_CYC(10), .REFRESH_CNT(2)) dut_u (.clk_in(clk_in),
        .sys_rst_in(sys_rst_in), .start_in(start_in), .regs_in(regs_in), .cmd_out(cmd_out),
        .mem_clk_en_out(mem_clk_en_out), .busy_out(busy_out), .done_out(done_out),
        .read_ok_out(read_ok_out));
    dmi_mem_model mem_u (.clk_in(clk_in), .clr_in(sys_rst_in), .cmd_in(cmd_out), .mr_out(mr),
        .ref_cnt_out(n_ref), .dll_cnt_out(n_dll), .e1_cnt_out(n_e1), .err_cnt_out(n_err));
    task automatic check(input logic [13:0] seen, input logic [13:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #5;
    endtask : tick
    task automatic run(input dmi_regs_t r);
        int k;
        regs_in = r;
        start_in = 1'b1;
        tick(1);
        start_in = 1'b0;
        tick(1);
        check(busy_out, 1'b1);
        check(read_ok_out, 1'b0);
        k = 0;
        while (done_out !== 1'b1 && k < 1000) begin
            tick(1);
            k++;
        end
        check(done_out, 1'b1);
    endtask : run
    task automatic check_row(input dmi_row_t w);
        check(mr[0], w.exp_main);
        check(mr[1], w.exp_ext1);
        check(mr[2], w.regs.ext2_val);
        check(mr[3], w.regs.ext3_val);
        check(n_ref, 14'h0002);
        check(n_e1, 14'h0002);
        check(n_err, 14'h0000);
        check(read_ok_out, 1'b1);
        check(busy_out, 1'b0);
    endtask : check_row
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict
    // Hang guard well above five start-ups
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        tick(8);
        check(cmd_out.cke, 1'b0);
        check(done_out, 1'b0);
        sys_rst_in = 1'b0;
        tick(1);
        check(mem_clk_en_out, 1'b1);
        for (int i = 0; i < 3; i++) begin
            run(rows[i].regs);
            check_row(rows[i]);
            $display("row %0d ended", i);
        end
        // Second start while busy must not restart
        regs_in = rows[0].regs;
        start_in = 1'b1;
        tick(1);
        start_in = 1'b0;
        tick(30);
        run(rows[0].regs);
        check(n_dll, 14'h0004);
        check_row(rows[0]);
        $display("busy start ended");
        start_in = 1'b1;
        tick(1);
        start_in = 1'b0;
        tick(20);
        sys_rst_in = 1'b1;
        tick(8);
        check(cmd_out.cke, 1'b0);
        check(cmd_out.cs_n, 1'b1);
        check(mem_clk_en_out, 1'b0);
        sys_rst_in = 1'b0;
        run(rows[1].regs);
        check(n_dll, 14'h0001);
        check_row(rows[1]);
        $display("mid reset ended");
        print_verdict();
    end
endmodule : tb_dmi_init_seq

//--- src/dmi_consts.svh
// Constants for the DDR2 power-up and mode programming sequencer.
// Assumes a 20 MHz controller clock that also drives the memory clock pins.
`ifndef DMI_CONSTS_SVH
`define DMI_CONSTS_SVH

`define DMI_CLK_MHZ 20
`define DMI_STABLE_US 200
`define DMI_STABLE_CYC (`DMI_STABLE_US * `DMI_CLK_MHZ)
`define DMI_CKE_WAIT_NS 400
`define DMI_CKE_WAIT_CYC ((`DMI_CKE_WAIT_NS * `DMI_CLK_MHZ + 999) / 1000)
`define DMI_DLL_LOCK_CYC 200
`define DMI_MRD_CYC 2
`define DMI_RP_CYC 2
`define DMI_RFC_CYC 4
`define DMI_REFRESH_CNT 2
// Bank selects of the mode set command
`define DMI_BANK_MAIN 2'h0
`define DMI_BANK_EXT1 2'h1
`define DMI_BANK_EXT2 2'h2
`define DMI_BANK_EXT3 2'h3
// Address field positions and calibration field values
`define DMI_DLL_RESET_BIT 8
`define DMI_CAL_LSB 7
`define DMI_CAL_DEFAULT 3'h7
`define DMI_CAL_EXIT 3'h0
`define DMI_PRECHARGE_ALL_BIT 10
`define DMI_DLL_DISABLE_BIT 0
`define DMI_TEST_MODE_BIT 7
`define DMI_RESERVED_BIT 13
// Command codes: chip select, row, column, write enable (active low)
`define DMI_CMD_NOP 4'h7
`define DMI_CMD_PRECHARGE 4'h2
`define DMI_CMD_REFRESH 4'h1
`define DMI_CMD_MODE_SET 4'h0
`define DMI_CMD_DESELECT 4'h8

`endif

//--- src/dmi_init_seq.sv
// Sequencer that powers up and programs a DDR2 memory's mode registers.
// Assumes memory clock is sourced from clk_in; user values are held stable.
`timescale 1ns/1ps
`include "dmi_consts.svh"

module dmi_init_seq #(
    parameter int unsigned STABLE_CYC = `DMI_STABLE_CYC,
    parameter int unsigned REFRESH_CNT = `DMI_REFRESH_CNT
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // User orders
    input wire logic start_in,
    input wire dmi_pkg::dmi_regs_t regs_in,
    // Memory command bus
    output dmi_pkg::dmi_cmd_t cmd_out,
    output logic mem_clk_en_out,
    // Status
    output logic busy_out,
    output logic done_out,
    output logic read_ok_out
);
    import dmi_pkg::*;

    dmi_state_rec_t cur_ff;
    dmi_state_rec_t nxt_cur;

    function automatic dmi_cmd_t mk_cmd(input logic [3:0] code, input logic [1:0] bank,
                                        input logic [13:0] addr);
        dmi_cmd_t c;
        c.cke = 1'b1;
        c.termination_control = 1'b0;
        c.cs_n = code[3];
        c.ras_n = code[2];
        c.cas_n = code[1];
        c.we_n = code[0];
        c.bank = bank;
        c.addr = addr;
        return c;
    endfunction : mk_cmd

    function automatic logic [13:0] pre_all();
        logic [13:0] a;
        a = 14'h0000;
        a[`DMI_PRECHARGE_ALL_BIT] = 1'b1;
        return a;
    endfunction : pre_all

    function automatic logic [13:0] with_cal(input logic [13:0] v, input logic [2:0] cal);
        logic [13:0] a;
        a = v;
        a[`DMI_CAL_LSB +: 3] = cal;
        return a;
    endfunction : with_cal

    function automatic logic [13:0] main_word(input logic [13:0] v, input logic dll_reset);
        logic [13:0] a;
        a = v;
        a[`DMI_DLL_RESET_BIT] = dll_reset;
        // Test mode and reserved bit forced low whatever the user supplies
        a[`DMI_TEST_MODE_BIT] = 1'b0;
        a[`DMI_RESERVED_BIT] = 1'b0;
        return a;
    endfunction : main_word

    always_comb begin
        logic [13:0] a;
        a = 14'h0000;
        nxt_cur = cur_ff;
        nxt_cur.cmd = mk_cmd(`DMI_CMD_NOP, 2'h0, 14'h0000);
        if (cur_ff.wait_cnt != 16'h0000) begin
            nxt_cur.wait_cnt = cur_ff.wait_cnt - 16'h0001;
        end
        if (cur_ff.dll_run && cur_ff.dll_cnt != 8'h00) begin
            nxt_cur.dll_cnt = cur_ff.dll_cnt - 8'h01;
        end
        case (cur_ff.st)
            DMI_POWER: begin
                nxt_cur.cmd = mk_cmd(`DMI_CMD_DESELECT, 2'h0, 14'h0000);
                nxt_cur.cmd.cke = 1'b0;
                if (start_in) begin
                    nxt_cur.st = DMI_STABLE;
                    nxt_cur.done = 1'b0;
                    nxt_cur.wait_cnt = 16'(STABLE_CYC);
                end
            end
            DMI_STABLE: begin
                nxt_cur.cmd.cke = 1'b0;
                if (cur_ff.wait_cnt == 16'h0000) begin
                    nxt_cur.st = DMI_CKE_WAIT;
                    nxt_cur.wait_cnt = 16'(`DMI_CKE_WAIT_CYC);
                end
            end
            DMI_CKE_WAIT: begin
                if (cur_ff.wait_cnt == 16'h0000) begin
                    nxt_cur.cmd = mk_cmd(`DMI_CMD_PRECHARGE, 2'h0, pre_all());
                    nxt_cur.st = DMI_PRE1;
                    nxt_cur.wait_cnt = 16'(`DMI_RP_CYC);
                end
            end
            DMI_PRE1: begin
                if (cur_ff.wait_cnt == 16'h0000) begin
                    nxt_cur.cmd = mk_cmd(`DMI_CMD_MODE_SET, `DMI_BANK_EXT2, regs_in.ext2_val);
                    nxt_cur.st = DMI_EXT2;
                    nxt_cur.wait_cnt = 16'(`DMI_MRD_CYC);
                end
            end
            DMI_EXT2: begin
                if (cur_ff.wait_cnt == 16'h0000) begin
                    nxt_cur.cmd = mk_cmd(`DMI_CMD_MODE_SET, `DMI_BANK_EXT3, regs_in.ext3_val);
                    nxt_cur.st = DMI_EXT3;
                    nxt_cur.wait_cnt = 16'(`DMI_MRD_CYC);
                end
            end
            DMI_EXT3: begin
                if (cur_ff.wait_cnt == 16'h0000) begin
                    a = with_cal(regs_in.ext1_val, `DMI_CAL_EXIT);
                    a[`DMI_DLL_DISABLE_BIT] = 1'b0;
                    a[`DMI_RESERVED_BIT] = 1'b0;
                    nxt_cur.cmd = mk_cmd(`DMI_CMD_MODE_SET, `DMI_BANK_EXT1, a);
                    nxt_cur.st = DMI_EXT1_DLL;
                    nxt_cur.wait_cnt = 16'(`DMI_MRD_CYC);
                end
            end
            DMI_EXT1_DLL: begin
                if (cur_ff.wait_cnt == 16'h0000) begin
                    a = main_word(regs_in.main_val, 1'b1);
                    nxt_cur.cmd = mk_cmd(`DMI_CMD_MODE_SET, `DMI_BANK_MAIN, a);
                    nxt_cur.st = DMI_MAIN_RST;
                    nxt_cur.wait_cnt = 16'(`DMI_MRD_CYC);
                    nxt_cur.dll_run = 1'b1;
                    nxt_cur.dll_cnt = 8'(`DMI_DLL_LOCK_CYC);
                end
            end
            DMI_MAIN_RST: begin
                if (cur_ff.wait_cnt == 16'h0000) begin
                    nxt_cur.cmd = mk_cmd(`DMI_CMD_PRECHARGE, 2'h0, pre_all());
                    nxt_cur.st = DMI_PRE2;
                    nxt_cur.wait_cnt = 16'(`DMI_RP_CYC);
                    nxt_cur.ref_cnt = 4'(REFRESH_CNT);
                end
            end
            DMI_PRE2, DMI_REFRESH: begin
                if (cur_ff.wait_cnt == 16'h0000) begin
                    if (cur_ff.ref_cnt != 4'h0) begin
                        nxt_cur.cmd = mk_cmd(`DMI_CMD_REFRESH, 2'h0, 14'h0000);
                        nxt_cur.st = DMI_REFRESH;
                        nxt_cur.ref_cnt = cur_ff.ref_cnt - 4'h1;
                        nxt_cur.wait_cnt = 16'(`DMI_RFC_CYC);
                    end else begin
                        a = main_word(regs_in.main_val, 1'b0);
                        nxt_cur.cmd = mk_cmd(`DMI_CMD_MODE_SET, `DMI_BANK_MAIN, a);
                        nxt_cur.st = DMI_MAIN_RUN;
                        nxt_cur.wait_cnt = 16'(`DMI_MRD_CYC);
                    end
                end
            end
            DMI_MAIN_RUN: begin
                if (cur_ff.wait_cnt == 16'h0000) begin
                    nxt_cur.st = DMI_CAL_WAIT;
                end
            end
            DMI_CAL_WAIT: begin
                if (cur_ff.dll_cnt == 8'h00) begin
                    a = with_cal(regs_in.ext1_val, `DMI_CAL_DEFAULT);
                    a[`DMI_RESERVED_BIT] = 1'b0;
                    nxt_cur.cmd = mk_cmd(`DMI_CMD_MODE_SET, `DMI_BANK_EXT1, a);
                    nxt_cur.st = DMI_CAL_DEF;
                    nxt_cur.wait_cnt = 16'(`DMI_MRD_CYC);
                end
            end
            DMI_CAL_DEF: begin
                if (cur_ff.wait_cnt == 16'h0000) begin
                    a = with_cal(regs_in.ext1_val, `DMI_CAL_EXIT);
                    a[`DMI_RESERVED_BIT] = 1'b0;
                    nxt_cur.cmd = mk_cmd(`DMI_CMD_MODE_SET, `DMI_BANK_EXT1, a);
                    nxt_cur.st = DMI_CAL_EXIT;
                    nxt_cur.wait_cnt = 16'(`DMI_MRD_CYC);
                end
            end
            DMI_CAL_EXIT: begin
                if (cur_ff.wait_cnt == 16'h0000) begin
                    nxt_cur.st = DMI_READY;
                    nxt_cur.done = 1'b1;
                end
            end
            DMI_READY: begin
                if (start_in) begin
                    nxt_cur.done = 1'b0;
                    nxt_cur.dll_run = 1'b0;
                    nxt_cur.cmd = mk_cmd(`DMI_CMD_PRECHARGE, 2'h0, pre_all());
                    nxt_cur.st = DMI_PRE1;
                    nxt_cur.wait_cnt = 16'(`DMI_RP_CYC);
                end
            end
            default: begin
                nxt_cur.st = DMI_POWER;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cur_ff <= '0;
            cur_ff.st <= DMI_POWER;
            cur_ff.cmd <= {1'b0, 1'b0, `DMI_CMD_DESELECT, 2'h0, 14'h0000};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign cmd_out = cur_ff.cmd;
    assign mem_clk_en_out = ~sys_rst_in;
    assign busy_out = (cur_ff.st != DMI_POWER) && (cur_ff.st != DMI_READY);
    assign done_out = cur_ff.done;
    assign read_ok_out = cur_ff.done && (cur_ff.dll_cnt == 8'h00);

endmodule : dmi_init_seq

//--- src/dmi_pkg.sv
// Types for the DDR2 initialization sequencer.
// Assumes the constants header is included by the user of the package.
package dmi_pkg;

    typedef enum logic [3:0] {
        DMI_POWER = 4'h0,
        DMI_STABLE = 4'h1,
        DMI_CKE_WAIT = 4'h3,
        DMI_PRE1 = 4'h2,
        DMI_EXT2 = 4'h6,
        DMI_EXT3 = 4'h7,
        DMI_EXT1_DLL = 4'h5,
        DMI_MAIN_RST = 4'h4,
        DMI_PRE2 = 4'hC,
        DMI_REFRESH = 4'hD,
        DMI_MAIN_RUN = 4'hF,
        DMI_CAL_WAIT = 4'hE,
        DMI_CAL_DEF = 4'hA,
        DMI_CAL_EXIT = 4'hB,
        DMI_READY = 4'h9
    } dmi_state_t;

    // Command bus driven to the memory
    typedef struct packed {
        logic cke;
        logic termination_control;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] bank;
        logic [13:0] addr;
    } dmi_cmd_t;

    // Register values supplied by the user
    typedef struct packed {
        logic [13:0] main_val;
        logic [13:0] ext1_val;
        logic [13:0] ext2_val;
        logic [13:0] ext3_val;
    } dmi_regs_t;

    typedef struct packed {
        dmi_state_t st;
        logic [15:0] wait_cnt;
        logic [7:0] dll_cnt;
        logic [3:0] ref_cnt;
        logic dll_run;
        logic done;
        dmi_cmd_t cmd;
    } dmi_state_rec_t;

endpackage : dmi_pkg
